//--- inc/psa_cfg.svh
`ifndef PSA_CFG_SVH
`define PSA_CFG_SVH
`define PSA_LEG_MASTERS 7
`define PSA_SEGB_MASTERS 3
`define PSA_SEGC_MASTERS 4
`define PSA_LEG_WIDTH 32
`define PSA_WIDE_WIDTH 64
`define PSA_SEL_VIDEO 18
`define PSA_SEL_NET1 19
`define PSA_SEL_NET2 20
`define PSA_SEL_SLOTA 24
`define PSA_SEL_SLOTB 25
`define PSA_SEL_SOUTH 31
`define PSA_SEL_STORAGE 20
`define PSA_CLK_FAST_MHZ 66
`define PSA_CLK_SLOW_MHZ 33
`endif

//--- inc/psa_pkg.sv
package psa_pkg;
  typedef enum logic [2:0] {
    PSA_IDLE  = 3'h1,
    PSA_GRANT = 3'h2,
    PSA_BUSY  = 3'h4
  } psa_state_t;
endpackage

//--- inc/psa_arb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface psa_arb_if #(parameter int N = 3);
  logic [N-1:0] req;
  logic [N-1:0] gnt;
  logic         frame;
  modport arb (input req, input frame, output gnt);
  modport top (output req, output frame, input gnt);
endinterface
`default_nettype wire

//--- rtl/psa_lru_arb.sv
`timescale 1ns/1ps
`default_nettype none
module psa_lru_arb #(
  parameter int N = 3
) (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // masters
  psa_arb_if.arb    bus
);
  import psa_pkg::*;
  localparam int IW = (N > 1) ? $clog2(N) : 1;

  // order_ff[0] is least recently granted
  logic [IW-1:0] order_ff [N];
  logic [IW-1:0] nxt_order [N];
  logic [N-1:0]  gnt_ff;
  logic [N-1:0]  nxt_gnt;
  psa_state_t    state_ff;
  psa_state_t    nxt_state;
  logic          found;
  logic [IW-1:0] pos;
  logic [IW-1:0] win;

  assign bus.gnt = gnt_ff;

  always_comb begin
    found = 1'b0;
    pos   = '0;
    win   = '0;
    for (int i = 0; i < N; i++) begin
      if (!found && bus.req[order_ff[i]]) begin
        found = 1'b1;
        pos   = IW'(i);
        win   = order_ff[i];
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_gnt   = gnt_ff;
    for (int i = 0; i < N; i++) begin
      nxt_order[i] = order_ff[i];
    end
    unique case (state_ff)
      PSA_IDLE: begin
        nxt_gnt = '0;
        if (found) begin
          nxt_gnt[win] = 1'b1;
          nxt_state    = PSA_GRANT;
          for (int i = 0; i < N - 1; i++) begin
            if (i >= int'(pos)) begin
              nxt_order[i] = order_ff[i+1];
            end
          end
          nxt_order[N-1] = win;
        end
      end
      PSA_GRANT: begin
        if (bus.frame) begin
          nxt_state = PSA_BUSY;
        end else if ((bus.req & gnt_ff) == '0) begin
          nxt_gnt   = '0;
          nxt_state = PSA_IDLE;
        end
      end
      PSA_BUSY: begin
        nxt_gnt = '0;
        if (!bus.frame) begin
          nxt_state = PSA_IDLE;
        end
      end
      default: begin
        nxt_gnt   = '0;
        nxt_state = PSA_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_ff <= PSA_IDLE;
      gnt_ff   <= '0;
      for (int i = 0; i < N; i++) begin
        order_ff[i] <= IW'(i);
      end
    end else begin
      state_ff <= nxt_state;
      gnt_ff   <= nxt_gnt;
      for (int i = 0; i < N; i++) begin
        order_ff[i] <= nxt_order[i];
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/psa_segments.sv
`timescale 1ns/1ps
`default_nettype none
`include "psa_cfg.svh"
module psa_segments #(
  parameter int LEG_N  = `PSA_LEG_MASTERS,
  parameter int SEGB_N = `PSA_SEGB_MASTERS,
  parameter int SEGC_N = `PSA_SEGC_MASTERS
) (
  // clock and reset
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  // legacy segment: 0 video,1..2 net,3..4 slots,5 south,6 host bridge
  input  wire logic [LEG_N-1:0]         legacy_request_n_i,
  input  wire logic                     legacy_frame_n_i,
  output logic      [LEG_N-1:0]         legacy_grant_n_o,
  // wide segment b: 0..1 slots, 2 io bridge
  input  wire logic [SEGB_N-1:0]        segb_request_n_i,
  input  wire logic                     segb_frame_n_i,
  output logic      [SEGB_N-1:0]        segb_grant_n_o,
  // wide segment c: 0 storage, 1..2 slots, 3 io bridge
  input  wire logic [SEGC_N-1:0]        segc_request_n_i,
  input  wire logic                     segc_frame_n_i,
  output logic      [SEGC_N-1:0]        segc_grant_n_o,
  // configuration address per segment
  input  wire logic [`PSA_LEG_WIDTH-1:0] legacy_ad_i,
  input  wire logic [`PSA_LEG_WIDTH-1:0] segb_ad_i,
  input  wire logic [`PSA_LEG_WIDTH-1:0] segc_ad_i,
  output logic      [5:0]                legacy_idsel_o,
  output logic      [1:0]                segb_idsel_o,
  output logic      [2:0]                segc_idsel_o,
  // slow-card presence and clock rate select
  input  wire logic [1:0]               segb_slow_card_i,
  input  wire logic [1:0]               segc_slow_card_i,
  output logic                          segb_slow_clk_o,
  output logic                          segc_slow_clk_o,
  // embedded legacy device disables
  input  wire logic [2:0]               legacy_disable_req_i,
  output logic      [2:0]               legacy_disable_o
);
  import psa_pkg::*;

  psa_arb_if #(.N(LEG_N))  leg_if ();
  psa_arb_if #(.N(SEGB_N)) segb_if ();
  psa_arb_if #(.N(SEGC_N)) segc_if ();

  logic [5:0] leg_sel_ff;
  logic [5:0] nxt_leg_sel;
  logic [1:0] segb_sel_ff;
  logic [1:0] nxt_segb_sel;
  logic [2:0] segc_sel_ff;
  logic [2:0] nxt_segc_sel;
  logic       segb_slow_ff;
  logic       nxt_segb_slow;
  logic       segc_slow_ff;
  logic       nxt_segc_slow;
  logic [2:0] dis_ff;
  logic [2:0] nxt_dis;

  // active-low pins to internal high-true
  assign leg_if.req    = ~legacy_request_n_i;
  assign leg_if.frame  = ~legacy_frame_n_i;
  assign segb_if.req   = ~segb_request_n_i;
  assign segb_if.frame = ~segb_frame_n_i;
  assign segc_if.req   = ~segc_request_n_i;
  assign segc_if.frame = ~segc_frame_n_i;
  assign legacy_grant_n_o = ~leg_if.gnt;
  assign segb_grant_n_o   = ~segb_if.gnt;
  assign segc_grant_n_o   = ~segc_if.gnt;

  psa_lru_arb #(.N(LEG_N)) u_leg_arb (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .bus       (leg_if.arb)
  );
  psa_lru_arb #(.N(SEGB_N)) u_segb_arb (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .bus       (segb_if.arb)
  );
  psa_lru_arb #(.N(SEGC_N)) u_segc_arb (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .bus       (segc_if.arb)
  );

  always_comb begin
    nxt_leg_sel = {legacy_ad_i[`PSA_SEL_SOUTH], legacy_ad_i[`PSA_SEL_SLOTB],
                   legacy_ad_i[`PSA_SEL_SLOTA], legacy_ad_i[`PSA_SEL_NET2],
                   legacy_ad_i[`PSA_SEL_NET1], legacy_ad_i[`PSA_SEL_VIDEO]};
    nxt_segb_sel = {segb_ad_i[`PSA_SEL_SLOTB], segb_ad_i[`PSA_SEL_SLOTA]};
    nxt_segc_sel = {segc_ad_i[`PSA_SEL_SLOTB], segc_ad_i[`PSA_SEL_SLOTA],
                    segc_ad_i[`PSA_SEL_STORAGE]};
    nxt_segb_slow = |segb_slow_card_i;
    nxt_segc_slow = |segc_slow_card_i;
    nxt_dis       = legacy_disable_req_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      leg_sel_ff   <= 6'h00;
      segb_sel_ff  <= 2'h0;
      segc_sel_ff  <= 3'h0;
      segb_slow_ff <= 1'b0;
      segc_slow_ff <= 1'b0;
      dis_ff       <= 3'h0;
    end else begin
      leg_sel_ff   <= nxt_leg_sel;
      segb_sel_ff  <= nxt_segb_sel;
      segc_sel_ff  <= nxt_segc_sel;
      segb_slow_ff <= nxt_segb_slow;
      segc_slow_ff <= nxt_segc_slow;
      dis_ff       <= nxt_dis;
    end
  end

  assign legacy_idsel_o   = leg_sel_ff;
  assign segb_idsel_o     = segb_sel_ff;
  assign segc_idsel_o     = segc_sel_ff;
  assign segb_slow_clk_o  = segb_slow_ff;
  assign segc_slow_clk_o  = segc_slow_ff;
  assign legacy_disable_o = dis_ff;
endmodule
`default_nettype wire

//--- bench/psa_seg_props.sv
`timescale 1ns/1ps
`default_nettype none
module psa_seg_props #(
  parameter int LEG_N  = 7,
  parameter int SEGB_N = 3,
  parameter int SEGC_N = 4
) (
  // clock and reset
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  // arbitration
  input wire logic [LEG_N-1:0]  legacy_request_n_i,
  input wire logic [LEG_N-1:0]  legacy_grant_n_o,
  input wire logic              segb_frame_n_i,
  input wire logic [SEGB_N-1:0] segb_grant_n_o,
  input wire logic [SEGC_N-1:0] segc_request_n_i,
  input wire logic [SEGC_N-1:0] segc_grant_n_o,
  // select and disable
  input wire logic [31:0]       legacy_ad_i,
  input wire logic [5:0]        legacy_idsel_o,
  input wire logic [2:0]        legacy_disable_req_i,
  input wire logic [2:0]        legacy_disable_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_b_busy;
    segb_grant_n_o != '1 && !segb_frame_n_i;
  endsequence
  property p_leg_one; $onehot0(~legacy_grant_n_o); endproperty
  a_leg_one: assert property (p_leg_one) else $error("legacy double grant");
  property p_b_one; $onehot0(~segb_grant_n_o); endproperty
  a_b_one: assert property (p_b_one) else $error("segment b double grant");
  property p_c_one; $onehot0(~segc_grant_n_o); endproperty
  a_c_one: assert property (p_c_one) else $error("segment c double grant");
  property p_leg_new;
    ((~legacy_grant_n_o) & $past(legacy_grant_n_o) & $past(legacy_request_n_i)) == '0;
  endproperty
  a_leg_new: assert property (p_leg_new) else $error("legacy grant without request");
  property p_c_new;
    ((~segc_grant_n_o) & $past(segc_grant_n_o) & $past(segc_request_n_i)) == '0;
  endproperty
  a_c_new: assert property (p_c_new) else $error("segment c grant without request");
  // the frame edge moves the arbiter to busy, which clears the grant one edge later
  property p_b_drop; s_b_busy |=> ##1 segb_grant_n_o == '1; endproperty
  a_b_drop: assert property (p_b_drop) else $error("grant kept after frame");
  property p_idsel;
    !$past(rst_i) |->
      legacy_idsel_o == $past({legacy_ad_i[31], legacy_ad_i[25:24], legacy_ad_i[20:18]});
  endproperty
  a_idsel: assert property (p_idsel) else $error("legacy select wrong");
  property p_dis; !$past(rst_i) |-> legacy_disable_o == $past(legacy_disable_req_i); endproperty
  a_dis: assert property (p_dis) else $error("disable wrong");
endmodule
bind psa_segments psa_seg_props #(.LEG_N(LEG_N), .SEGB_N(SEGB_N), .SEGC_N(SEGC_N))
  psa_seg_props_i (.*);
`default_nettype wire

//--- bench/psa_master.sv
`timescale 1ns/1ps
`default_nettype none
module psa_master #(
  parameter int N = 3
) (
  // clock and control
  input  wire logic         clk_i,
  input  wire logic         clr_i,
  input  wire logic [N-1:0] want_i,
  // bus
  input  wire logic [N-1:0] grant_n_i,
  output logic      [N-1:0] request_n_o,
  output var logic          frame_n_o
);
  logic [N-1:0] done_ff;
  initial frame_n_o = 1'b1;
  // request held until granted, then one short frame
  assign request_n_o = ~(want_i & ~done_ff);
  always @(posedge clk_i) begin
    if (clr_i) begin
      done_ff   <= '0;
      frame_n_o <= 1'b1;
    end else if ((~grant_n_i & ~done_ff) != '0 && frame_n_o) begin
      done_ff   <= done_ff | ~grant_n_i;
      frame_n_o <= 1'b0;
    end else begin
      frame_n_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, clr = 1'b1;
  logic [6:0] want_l = '0, legacy_request_n_i, legacy_grant_n_o;
  logic [2:0] want_b = '0, segb_request_n_i, segb_grant_n_o;
  logic [3:0] want_c = '0, segc_request_n_i, segc_grant_n_o;
  logic legacy_frame_n_i, segb_frame_n_i, segc_frame_n_i, segb_slow_clk_o, segc_slow_clk_o;
  logic [31:0] legacy_ad_i = '0, segb_ad_i = '0, segc_ad_i = '0;
  logic [1:0] segb_slow_card_i = '0, segc_slow_card_i = '0, segb_idsel_o;
  logic [2:0] legacy_disable_req_i = '0, legacy_disable_o, segc_idsel_o;
  logic [5:0] legacy_idsel_o;
  int num_errors = 0, total_checks = 0, k;
  int ord [3][7];
  int n [3] = '{7, 3, 4};
  always #10 ref_clk_i = ~ref_clk_i;
  psa_segments psa_segments_i (.*);
  psa_master #(.N(7)) psa_master_i (.clk_i(ref_clk_i), .clr_i(clr), .want_i(want_l),
    .grant_n_i(legacy_grant_n_o), .request_n_o(legacy_request_n_i), .frame_n_o(legacy_frame_n_i));
  psa_master #(.N(3)) psa_master_b_i (.clk_i(ref_clk_i), .clr_i(clr), .want_i(want_b),
    .grant_n_i(segb_grant_n_o), .request_n_o(segb_request_n_i), .frame_n_o(segb_frame_n_i));
  psa_master #(.N(4)) psa_master_c_i (.clk_i(ref_clk_i), .clr_i(clr), .want_i(want_c),
    .grant_n_i(segc_grant_n_o), .request_n_o(segc_request_n_i), .frame_n_o(segc_frame_n_i));
  task end_sim;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task check(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // least recently granted requester wins
  function automatic int winner(int s, logic [6:0] p);
    for (int i = 0; i < n[s]; i++) if (p[ord[s][i]]) return ord[s][i];
    return 0;
  endfunction
  function automatic void to_back(int s, int e);
    int p = 0;
    for (int i = 0; i < n[s]; i++) if (ord[s][i] != e) begin
      ord[s][p] = ord[s][i];
      p++;
    end
    ord[s][n[s]-1] = e;
  endfunction
  task arb(input int s, input logic [6:0] w);
    logic [6:0] g, pg;
    int e;
    w = w & 7'((1 << n[s]) - 1);
    if (w == '0) w = 7'h01;
    pg = 7'h7F;
    {want_l, want_b, want_c} = {(s == 0) ? w : 7'h00, (s == 1) ? w[2:0] : 3'h0,
      (s == 2) ? w[3:0] : 4'h0};
    for (int j = 0; j < 200 && w != '0; j++) begin
      @(posedge ref_clk_i);
      #1;
      g = (s == 0) ? legacy_grant_n_o : (s == 1) ? {4'hF, segb_grant_n_o} : {3'h7, segc_grant_n_o};
      if (g != 7'h7F && pg == 7'h7F) begin
        e = winner(s, w);
        check(g === ~(7'h01 << e), "wrong grant");
        to_back(s, e);
        w[e] = 1'b0;
      end
      pg = g;
    end
    if (w != '0) begin
      check(1'b0, "grant timeout");
      end_sim;
    end
    {want_l, want_b, want_c} = '0;
    repeat (4) @(posedge ref_clk_i);
    #1 clr = 1'b1;
    @(posedge ref_clk_i);
    #1 clr = 1'b0;
  endtask
  initial begin
    k = $urandom(32'h0400);
    foreach (ord[s, i]) ord[s][i] = i;
    repeat (12) @(posedge ref_clk_i);
    #1 {rst_i, clr} = 2'b00;
    arb(0, 7'h7F);
    arb(1, 7'h7F);
    arb(2, 7'h7F);
    repeat (30) arb($urandom_range(2), 7'($urandom));
    repeat (60) begin
      {legacy_ad_i, segb_ad_i, segc_ad_i} = {$urandom, $urandom, $urandom};
      {segb_slow_card_i, segc_slow_card_i, legacy_disable_req_i} = 7'($urandom);
      @(posedge ref_clk_i);
      #1;
      check(legacy_idsel_o === {legacy_ad_i[31], legacy_ad_i[25:24], legacy_ad_i[20:18]},
        "legacy select");
      check({segc_idsel_o, segb_idsel_o} === {segc_ad_i[25:24], segc_ad_i[20], segb_ad_i[25:24]},
        "wide select");
      check({segc_slow_clk_o, segb_slow_clk_o} === {|segc_slow_card_i, |segb_slow_card_i},
        "slow clock");
      check(legacy_disable_o === legacy_disable_req_i, "disable");
    end
    end_sim;
  end
endmodule
`default_nettype wire
